// *** common/i2c_slave_defines.vh ***
`ifndef I2C_SLAVE_DEFINES_VH
`define I2C_SLAVE_DEFINES_VH

// register indexes on the plain register port
`define A_DBR      3'h0
`define A_OAR      3'h1
`define A_BR0      3'h2
`define A_BR1      3'h3
`define A_CR1      3'h4
`define A_CR2      3'h5

// control register two (write) and status register (read) bit positions
`define B_MST      7
`define B_TRX      6
`define B_BB       5
`define B_PIN      4
`define F_MODE_HI  3
`define F_MODE_LO  2
`define F_KEY_HI   1
`define F_KEY_LO   0
`define B_AL       3
`define B_AAS      2
`define B_AD0      1
`define B_LRB      0

// other field positions
`define B_ACK      4
`define B_BGE      7
`define B_IDS      6
`define B_ALS      0
`define F_SA_HI    7
`define F_SA_LO    1

// reset values and encodings
`define RST_BYTE   8'h00
`define RST_MODE   2'h0
`define MODE_BUS   2'h2
`define KEY_ARM    2'h2
`define KEY_FIRE   2'h1
`define GCALL      8'h00
`define START_CMD  4'hF
`define BIT_LAST   4'h8
`define BIT_NINTH  4'h9
`define BIT_ZERO   4'h0

// bus timing: least half period of the generated clock
`define T_HALF_NS  5000

`endif

// *** rtl/sync2.v ***
`timescale 1ns/100ps

// two flip-flop synchroniser; the first stage feeds only the second
module sync2 #(
    parameter         W   = 1,
    parameter [W-1:0] RST = {W{1'b1}}
) (
    input  wire         i_clk,
    input  wire         i_resetn,
    input  wire [W-1:0] i_d,
    output wire [W-1:0] o_q
);

    reg [W-1:0] meta_reg;
    reg [W-1:0] q_reg;

    // two stages, reset to bus idle level
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            meta_reg <= RST;
            q_reg    <= RST;
        end else begin
            meta_reg <= i_d;
            q_reg    <= meta_reg;
        end
    end

    assign o_q = q_reg;

endmodule // sync2

// *** rtl/serial_bus_interface.v ***
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
`include "i2c_slave_defines.vh"

module serial_bus_interface #(
    parameter CLK_MHZ = 100
) (
    input  wire       i_clk,
    input  wire       i_resetn,
    input  wire [2:0] i_addr,
    input  wire [7:0] i_wdata,
    input  wire       i_wr,
    input  wire       i_rd,
    output wire [7:0] o_rdata,
    input  wire       i_scl,
    output wire       o_scl,
    output wire       o_scl_oe,
    input  wire       i_sda,
    output wire       o_sda,
    output wire       o_sda_oe,
    output wire       o_transfer_interrupt,
    output wire [1:0] o_interface_mode_select,
    output wire       o_baud_generator_enable,
    output wire       o_idle_shutdown_select
);

    // generated clock half period in cycles, rounded up
    localparam integer   HALF_INT = (`T_HALF_NS * CLK_MHZ + 999) / 1000;
    localparam [11:0]    HALF_CYC = HALF_INT[11:0];
    localparam [11:0]    QTR_CYC  = HALF_CYC >> 1;

    // master engine states
    localparam [2:0] M_IDLE  = 3'h0;
    localparam [2:0] M_START = 3'h1;
    localparam [2:0] M_LOW   = 3'h2;
    localparam [2:0] M_HIGH  = 3'h3;
    localparam [2:0] M_HOLD  = 3'h4;

    wire [1:0] pin_sync;
    wire       scl_s;
    wire       sda_s;

    reg  [7:0]  dbr_reg;
    reg  [7:0]  oar_reg;
    reg  [7:0]  br0_reg;
    reg  [7:0]  br1_reg;
    reg  [7:0]  cr1_reg;
    reg         mst_reg;
    reg         trx_reg;
    reg         bb_reg;
    reg         pin_reg;
    reg  [1:0]  mode_reg;
    reg         armed_reg;
    reg         srst_reg;
    reg         aas_reg;
    reg         ad0_reg;
    reg         lrb_reg;
    reg         int_reg;
    reg  [7:0]  rdata_reg;
    reg  [2:0]  m_state_reg;
    reg  [11:0] m_cnt_reg;
    reg  [3:0]  m_bit_reg;
    reg  [7:0]  m_shift_reg;
    reg         m_addr_reg;
    reg         m_rw_reg;
    reg         m_sda_reg;
    reg  [3:0]  rcnt_reg;
    reg  [7:0]  rx_reg;
    reg         first_reg;
    reg         match_reg;
    reg         sel_reg;
    reg         s_ack_reg;
    reg         scl_d_reg;
    reg         sda_d_reg;
    reg  [7:0]  rd_mux;

    wire        do_rst;
    wire        bus_mode;
    wire        scl_rise;
    wire        scl_fall;
    wire        bus_start;
    wire        bus_stop;
    wire        dbr_acc;
    wire        cr2_wr;
    wire        start_req;
    wire        address_match_disable;
    wire        ack_en;
    wire        m_drive;
    wire        addr_hit;

    // pin inputs pass two flip-flops before use
    sync2 #(
        .W   (2),
        .RST (2'h3)
    ) u_pin_sync (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_d      ({i_scl, i_sda}),
        .o_q      (pin_sync)
    );

    assign scl_s = pin_sync[1];
    assign sda_s = pin_sync[0];

    // bus condition and clock edge detection
    assign scl_rise  = scl_s & ~scl_d_reg;
    assign scl_fall  = ~scl_s & scl_d_reg;
    assign bus_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    assign bus_stop  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

    // decoded accesses and configuration
    assign do_rst   = ~i_resetn | srst_reg;
    assign bus_mode = (mode_reg == `MODE_BUS);
    assign dbr_acc  = (i_wr | i_rd) & (i_addr == `A_DBR);
    assign cr2_wr   = i_wr & (i_addr == `A_CR2);
    assign address_match_disable      = oar_reg[`B_ALS];
    assign ack_en   = cr1_reg[`B_ACK];
    assign addr_hit = (rx_reg[7:1] == oar_reg[`F_SA_HI:`F_SA_LO]) |
                      (rx_reg == `GCALL);

    // start command: ones to master, transmit, busy and pending bits
    assign start_req = cr2_wr & (i_wdata[`B_MST:`B_PIN] == `START_CMD) & ~bb_reg &
                       (i_wdata[`F_MODE_HI:`F_MODE_LO] == `MODE_BUS) &
                       br1_reg[`B_BGE];

    // pull-low enable the master puts on SDA for the current slot (1 drives SDA low)
    assign m_drive = (m_bit_reg < `BIT_LAST) ? (trx_reg & ~m_shift_reg[7]) :
                     (~trx_reg & ack_en);

    // register read multiplexer
    always @* begin
        if (i_addr == `A_DBR) begin
            rd_mux = dbr_reg;
        end else if (i_addr == `A_OAR) begin
            rd_mux = oar_reg;
        end else if (i_addr == `A_BR0) begin
            rd_mux = br0_reg;
        end else if (i_addr == `A_BR1) begin
            rd_mux = br1_reg;
        end else if (i_addr == `A_CR1) begin
            rd_mux = cr1_reg;
        end else if (i_addr == `A_CR2) begin
            rd_mux = {mst_reg, trx_reg, bb_reg, pin_reg,
                      1'b0, aas_reg, ad0_reg, lrb_reg};
        end else begin
            rd_mux = `RST_BYTE;
        end
    end

    // edge history for the synchronised bus lines
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end

    // registers, soft reset, status flags, bus receiver, master engine
    always @(posedge i_clk) begin
        if (do_rst) begin
            dbr_reg     <= `RST_BYTE;
            oar_reg     <= `RST_BYTE;
            br0_reg     <= `RST_BYTE;
            br1_reg     <= `RST_BYTE;
            cr1_reg     <= `RST_BYTE;
            mst_reg     <= 1'b0;
            trx_reg     <= 1'b0;
            bb_reg      <= 1'b0;
            pin_reg     <= 1'b1;
            mode_reg    <= `RST_MODE;
            armed_reg   <= 1'b0;
            srst_reg    <= 1'b0;
            aas_reg     <= 1'b0;
            ad0_reg     <= 1'b0;
            lrb_reg     <= 1'b0;
            int_reg     <= 1'b0;
            rdata_reg   <= `RST_BYTE;
            m_state_reg <= M_IDLE;
            m_cnt_reg   <= 12'h000;
            m_bit_reg   <= `BIT_ZERO;
            m_shift_reg <= `RST_BYTE;
            m_addr_reg  <= 1'b0;
            m_rw_reg    <= 1'b0;
            m_sda_reg   <= 1'b0;
            rcnt_reg    <= `BIT_ZERO;
            rx_reg      <= `RST_BYTE;
            first_reg   <= 1'b0;
            match_reg   <= 1'b0;
            sel_reg     <= 1'b0;
            s_ack_reg   <= 1'b0;
        end else begin
            int_reg   <= 1'b0;
            srst_reg  <= 1'b0;
            rdata_reg <= i_rd ? rd_mux : `RST_BYTE;

            // software writes
            if (i_wr) begin
                if (i_addr == `A_DBR) begin
                    dbr_reg <= i_wdata;
                end else if (i_addr == `A_OAR) begin
                    oar_reg <= i_wdata;
                end else if (i_addr == `A_BR0) begin
                    br0_reg <= i_wdata;
                end else if (i_addr == `A_BR1) begin
                    br1_reg <= i_wdata;
                end else if (i_addr == `A_CR1) begin
                    cr1_reg <= i_wdata;
                end else if (i_addr == `A_CR2) begin
                    mst_reg  <= i_wdata[`B_MST];
                    trx_reg  <= i_wdata[`B_TRX];
                    mode_reg <= i_wdata[`F_MODE_HI:`F_MODE_LO];
                    if (i_wdata[`B_PIN]) begin
                        pin_reg <= 1'b1;      // a zero write has no effect
                    end
                end
            end

            // two-write reset key, any other value abandons it
            if (cr2_wr) begin
                if (i_wdata[`F_KEY_HI:`F_KEY_LO] == `KEY_ARM) begin
                    armed_reg <= 1'b1;
                end else if ((i_wdata[`F_KEY_HI:`F_KEY_LO] == `KEY_FIRE) &&
                             armed_reg) begin
                    armed_reg <= 1'b0;
                    srst_reg  <= 1'b1;
                end else begin
                    armed_reg <= 1'b0;
                end
            end

            // data buffer access clears the addressed flag, releases the clock
            if (dbr_acc) begin
                aas_reg <= 1'b0;
                pin_reg <= 1'b1;
            end

            // bus busy and start/stop tracking
            if (bus_start) begin
                bb_reg    <= 1'b1;
                ad0_reg   <= 1'b0;
                rcnt_reg  <= `BIT_ZERO;
                first_reg <= 1'b1;
                sel_reg   <= 1'b0;
                match_reg <= 1'b0;
            end else if (bus_stop) begin
                bb_reg    <= 1'b0;
                ad0_reg   <= 1'b0;
                first_reg <= 1'b0;
                sel_reg   <= 1'b0;
                s_ack_reg <= 1'b0;
                mst_reg   <= 1'b0;
                trx_reg   <= 1'b0;
            end else if (scl_rise) begin
                lrb_reg <= sda_s;
                if (rcnt_reg < `BIT_LAST) begin
                    rx_reg <= {rx_reg[6:0], sda_s};
                end
                if (rcnt_reg < `BIT_NINTH) begin
                    rcnt_reg <= rcnt_reg + 4'h1;
                end
            end else if (scl_fall && (rcnt_reg == `BIT_LAST)) begin
                // eight bits in: decide on acknowledge
                if (!trx_reg && (mst_reg || sel_reg || address_match_disable || !first_reg)) begin
                    dbr_reg <= rx_reg;
                end
                if (!mst_reg && bus_mode) begin
                    if (first_reg && !address_match_disable) begin
                        match_reg <= addr_hit;
                        s_ack_reg <= addr_hit;
                        sel_reg   <= addr_hit;
                    end else if ((sel_reg || address_match_disable) && !trx_reg) begin
                        s_ack_reg <= ack_en;
                        sel_reg   <= 1'b1;
                    end
                end
            end else if (scl_fall && (rcnt_reg == `BIT_NINTH)) begin
                // end of the ninth clock
                rcnt_reg  <= `BIT_ZERO;
                first_reg <= 1'b0;
                s_ack_reg <= 1'b0;
                if (!mst_reg && bus_mode) begin
                    if (first_reg && !address_match_disable && match_reg) begin
                        int_reg <= 1'b1;
                        pin_reg <= 1'b0;
                        aas_reg <= 1'b1;
                        trx_reg <= rx_reg[0] & (rx_reg != `GCALL);
                        if (rx_reg == `GCALL) begin
                            ad0_reg <= 1'b1;
                        end
                    end else if (first_reg && address_match_disable) begin
                        int_reg <= 1'b1;
                        pin_reg <= 1'b0;
                        aas_reg <= 1'b1;
                    end else if (sel_reg) begin
                        int_reg <= 1'b1;
                        pin_reg <= 1'b0;
                    end
                end
            end

            // master engine: start, nine clocks, hold low while pending
            case (m_state_reg)
                M_IDLE: begin
                    if (start_req) begin
                        m_state_reg <= M_START;
                        m_cnt_reg   <= 12'h000;
                        m_bit_reg   <= `BIT_ZERO;
                        m_shift_reg <= dbr_reg;
                        m_rw_reg    <= dbr_reg[0];
                        m_addr_reg  <= 1'b1;
                        m_sda_reg   <= 1'b1;
                        pin_reg     <= 1'b1;
                    end
                end
                M_START: begin
                    m_cnt_reg <= m_cnt_reg + 12'h001;
                    if (m_cnt_reg == HALF_CYC) begin
                        m_state_reg <= M_LOW;
                        m_cnt_reg   <= 12'h000;
                    end
                end
                M_LOW: begin
                    m_cnt_reg <= m_cnt_reg + 12'h001;
                    if (m_cnt_reg == QTR_CYC) begin
                        m_sda_reg <= m_drive;
                    end
                    if (m_cnt_reg == HALF_CYC) begin
                        m_state_reg <= M_HIGH;
                        m_cnt_reg   <= 12'h000;
                    end
                end
                M_HIGH: begin
                    if (scl_s) begin
                        m_cnt_reg <= m_cnt_reg + 12'h001;
                    end
                    if (scl_s && (m_cnt_reg == HALF_CYC)) begin
                        m_cnt_reg <= 12'h000;
                        if (m_bit_reg == `BIT_LAST) begin
                            m_state_reg <= M_HOLD;
                            int_reg     <= 1'b1;
                            pin_reg     <= 1'b0;
                            if (m_addr_reg && !lrb_reg) begin
                                trx_reg <= ~m_rw_reg;
                            end
                        end else begin
                            m_bit_reg   <= m_bit_reg + 4'h1;
                            m_shift_reg <= {m_shift_reg[6:0], 1'b0};
                            m_state_reg <= M_LOW;
                        end
                    end
                end
                M_HOLD: begin
                    if (pin_reg) begin
                        m_state_reg <= M_LOW;
                        m_cnt_reg   <= 12'h000;
                        m_bit_reg   <= `BIT_ZERO;
                        m_addr_reg  <= 1'b0;
                        m_shift_reg <= dbr_reg;
                    end
                    if (!mst_reg) begin
                        m_state_reg <= M_IDLE;
                        m_sda_reg   <= 1'b0;
                    end
                end
                default: begin
                    m_state_reg <= M_IDLE;
                end
            endcase
        end
    end

    // pin drivers: open drain, low whenever enabled
    assign o_scl    = 1'b0;
    assign o_sda    = 1'b0;
    assign o_scl_oe = (m_state_reg == M_LOW) |
                      (m_state_reg == M_HOLD) |
                      (sel_reg & ~pin_reg & ~mst_reg);
    assign o_sda_oe = (m_sda_reg & (m_state_reg != M_IDLE)) |
                      s_ack_reg;

    // user side outputs
    assign o_rdata                 = rdata_reg;
    assign o_transfer_interrupt    = int_reg;
    assign o_interface_mode_select = mode_reg;
    assign o_baud_generator_enable = br1_reg[`B_BGE];
    assign o_idle_shutdown_select  = br0_reg[`B_IDS];

endmodule // serial_bus_interface

// *** tb/sbi_props.sv ***
`timescale 1ns/100ps
// port-level checker for the serial bus interface
module sbi_props (
    input wire       i_clk,
    input wire       i_resetn,
    input wire [2:0] i_addr,
    input wire [7:0] i_wdata,
    input wire       i_wr,
    input wire       i_rd,
    input wire [7:0] o_rdata,
    input wire       i_scl,
    input wire       o_scl,
    input wire       o_scl_oe,
    input wire       i_sda,
    input wire       o_sda,
    input wire       o_sda_oe,
    input wire       o_transfer_interrupt,
    input wire [1:0] o_interface_mode_select,
    input wire       o_baud_generator_enable,
    input wire       o_idle_shutdown_select
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    // control register two writes, split by soft reset key value
    wire cr2  = i_wr && (i_addr == 3'h5);
    wire arm  = cr2 && (i_wdata[1:0] == 2'h2);
    wire off  = cr2 && (i_wdata[1:0] == 2'h0);
    wire fire = cr2 && (i_wdata[1:0] == 2'h1);
    wire irq  = o_transfer_interrupt;
    property p_pulse; irq |=> !irq; endproperty
    a_pulse: assert property (p_pulse) else $error("interrupt too long");
    property p_hold; irq |-> ##[0:2] o_scl_oe; endproperty
    a_hold: assert property (p_hold) else $error("clock not pulled low");
    property p_held; irq ##1 (!i_wr && !i_rd) [*6] |-> o_scl_oe; endproperty
    a_held: assert property (p_held) else $error("clock released early");
    property p_sda; irq |-> !o_sda_oe; endproperty
    a_sda: assert property (p_sda) else $error("data held past ninth clock");
    property p_mode; cr2 && !fire |=> o_interface_mode_select == $past(i_wdata[3:2]); endproperty
    a_mode: assert property (p_mode) else $error("mode not stored");
    property p_srst;
        arm ##1 fire |=> ##1 (o_interface_mode_select == 2'h0 && !o_scl_oe && !o_sda_oe
            && !o_baud_generator_enable && !o_idle_shutdown_select);
    endproperty
    a_srst: assert property (p_srst) else $error("soft reset missing");
    property p_nofire;
        arm ##1 off ##1 (fire && i_wdata[3:2] == 2'h2) |=> ##1 o_interface_mode_select == 2'h2;
    endproperty
    a_nofire: assert property (p_nofire) else $error("broken key sequence fired");
    property p_bge; i_wr && i_addr == 3'h3 |=> o_baud_generator_enable == $past(i_wdata[7]); endproperty
    a_bge: assert property (p_bge) else $error("baud enable wrong");
    property p_ids; i_wr && i_addr == 3'h2 |=> o_idle_shutdown_select == $past(i_wdata[6]); endproperty
    a_ids: assert property (p_ids) else $error("idle select wrong");
    // main scenarios reached
    c_irq: cover property (irq);
    c_srst: cover property (arm ##1 fire);
    c_ack: cover property ($rose(o_sda_oe));
endmodule // sbi_props

bind serial_bus_interface sbi_props i_sbi_props (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_scl(i_scl), .o_scl(o_scl),
    .o_scl_oe(o_scl_oe), .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
    .o_transfer_interrupt(o_transfer_interrupt),
    .o_interface_mode_select(o_interface_mode_select),
    .o_baud_generator_enable(o_baud_generator_enable),
    .o_idle_shutdown_select(o_idle_shutdown_select));

// *** tb/bus_model.sv ***
`timescale 1ns/100ps
// far side of the two-wire bus: master tasks and a listening slave
module bus_model (
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    input  wire logic       i_listen,
    output logic            o_scl_low,
    output logic            o_sda_low,
    output logic      [7:0] o_rx
);
    logic [3:0] cnt = 4'hA;
    initial begin
        o_scl_low = 1'b0;
        o_sda_low = 1'b0;
        o_rx = 8'h00;
    end
    // data falls while the clock is high
    task start();
        #2 o_sda_low = 1'b1;   // off the clock edge
        #40 o_scl_low = 1'b1;
    endtask
    // eight bits msb first, then release data and sample the answer
    task xfer(input logic [7:0] b, output logic ack);
        for (int k = 7; k >= 0; k--) begin
            #20 o_sda_low = ~b[k];
            #20 o_scl_low = 1'b0;
            wait (i_scl);   // the device may stretch the clock
            #40 o_scl_low = 1'b1;
        end
        #20 o_sda_low = 1'b0;
        #20 o_scl_low = 1'b0;
        wait (i_scl);
        ack = i_sda;
        #40 o_scl_low = 1'b1;
    endtask
    // data rises while the clock is high
    task stop();
        #22 o_sda_low = 1'b1;
        #20 o_scl_low = 1'b0;
        wait (i_scl);
        #40 o_sda_low = 1'b0;
    endtask
    // a start primes the count so its own falling clock gives zero
    always @(negedge i_sda) if (i_scl) cnt = 4'hF;
    // shift in the eight data bits
    always @(posedge i_scl) if (cnt < 4'h8) o_rx = {o_rx[6:0], i_sda};
    // acknowledge during the ninth clock
    always @(negedge i_scl) begin
        if (cnt != 4'hA) cnt = cnt + 4'h1;
        if (i_listen && cnt == 4'h8) o_sda_low = 1'b1;
        if (i_listen && cnt == 4'h9) o_sda_low = 1'b0;
    end
endmodule // bus_model

// *** tb/tb.sv ***
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
    logic        i_clk, i_resetn, i_wr, i_rd, ack, got, listen;
    logic  [2:0] i_addr;
    logic  [7:0] i_wdata, own, byt, st_e, st_m, rx;
    logic        ack_e, int_e;
    wire   [7:0] o_rdata;
    wire         scl_oe, sda_oe, m_scl, m_sda, irq, bge, ids, d_scl, d_sda;
    wire   [1:0] mode;
    wire         scl_w = (scl_oe ? d_scl : 1'b1) & ~m_scl;   // pulled-up open-drain wires
    wire         sda_w = (sda_oe ? d_sda : 1'b1) & ~m_sda;
    int          n_errors = 0;
    int          n_compared = 0;
    // own address, byte sent, ack, interrupt, status, status mask
    logic [33:0] rows [4] = '{
        {8'hA4, 8'hA5, 1'b0, 1'b1, 8'h64, 8'hFF},
        {8'hA4, 8'h22, 1'b1, 1'b0, 8'h31, 8'hFF},
        {8'hA4, 8'h00, 1'b0, 1'b1, 8'h26, 8'hFF},
        {8'hA5, 8'hA4, 1'b0, 1'b1, 8'h04, 8'h04}};

    serial_bus_interface i_serial_bus_interface (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_scl(scl_w), .o_scl(d_scl),
        .o_scl_oe(scl_oe), .i_sda(sda_w), .o_sda(d_sda), .o_sda_oe(sda_oe),
        .o_transfer_interrupt(irq), .o_interface_mode_select(mode),
        .o_baud_generator_enable(bge), .o_idle_shutdown_select(ids));
    bus_model i_bus_model (.i_scl(scl_w), .i_sda(sda_w), .i_listen(listen),
        .o_scl_low(m_scl), .o_sda_low(m_sda), .o_rx(rx));

    // clock
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // one register port cycle; strobes stay until the next call
    task acc(input logic [2:0] a, input logic [7:0] d, input logic w, input logic r);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= w;
        i_rd <= r;
        @(posedge i_clk);
    endtask
    task wr(input logic [2:0] a, input logic [7:0] d);
        acc(a, d, 1'b1, 1'b0);
        i_wr <= 1'b0;
        @(posedge i_clk);
    endtask
    task rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
        acc(a, 8'h00, 1'b0, 1'b1);
        i_rd <= 1'b0;
        #1 `CHK(o_rdata & m, e & m)
        @(posedge i_clk);
    endtask
    // bounded wait for the interrupt pulse, then a quiet spell
    task wait_int(input int lim);
        got = 1'b0;
        for (int k = 0; k < lim && !got; k++) begin
            @(posedge i_clk);
            #1 got = irq;
        end
        repeat (10) @(posedge i_clk);
    endtask
    task complete_run();
        $display("n_errors=%0d n_compared=%0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // watchdog
    initial begin
        repeat (60000) @(posedge i_clk);
        n_errors++;
        complete_run();
    end
    // main sequence
    initial begin
        {i_resetn, i_wr, i_rd, i_addr, i_wdata, listen} = '0;
        repeat (6) @(posedge i_clk);
        i_resetn <= 1'b1;
        @(posedge i_clk);
        rd(3'h5, 8'h10, 8'hFF);
        wr(3'h2, 8'h40);
        wr(3'h3, 8'h80);
        wr(3'h4, 8'h10);
        wr(3'h6, 8'h5A);
        rd(3'h2, 8'h40, 8'hFF);
        rd(3'h3, 8'h80, 8'hFF);
        rd(3'h4, 8'h10, 8'hFF);
        rd(3'h6, 8'h00, 8'hFF);
        wr(3'h5, 8'h18);
        `CHK({bge, ids, mode}, 4'hE)
        foreach (rows[k]) begin
            {own, byt, ack_e, int_e, st_e, st_m} = rows[k];
            wr(3'h1, own);
            i_bus_model.start();
            i_bus_model.xfer(byt, ack);
            `CHK(ack, ack_e)
            wait_int(40);
            `CHK(got, int_e)
            rd(3'h5, st_e, st_m);
            rd(3'h0, byt, {8{own[0]}});
            rd(3'h5, (st_e & 8'hFB) | 8'h10, st_m);
            i_bus_model.stop();
            repeat (20) @(posedge i_clk);
            rd(3'h5, 8'h10, st_m);
        end
        // master start with the far side acknowledging
        wr(3'h1, 8'hA4);
        listen = 1'b1;
        rd(3'h5, 8'h10, 8'hFF);
        wr(3'h0, 8'hA6);
        wr(3'h5, 8'hF8);
        wait_int(25000);
        `CHK(got, 1'b1)
        `CHK(rx, 8'hA6)
        rd(3'h5, 8'hE0, 8'hFF);
        // broken key sequence, then a real soft reset
        acc(3'h5, 8'h0A, 1'b1, 1'b0);
        acc(3'h5, 8'h08, 1'b1, 1'b0);
        acc(3'h5, 8'h09, 1'b1, 1'b0);
        i_wr <= 1'b0;
        repeat (2) @(posedge i_clk);
        `CHK(mode, 2'h2)
        rd(3'h1, 8'hA4, 8'hFF);
        acc(3'h5, 8'h0A, 1'b1, 1'b0);
        acc(3'h5, 8'h09, 1'b1, 1'b0);
        i_wr <= 1'b0;
        repeat (2) @(posedge i_clk);
        `CHK({mode, bge, ids}, 4'h0)
        rd(3'h1, 8'h00, 8'hFF);
        rd(3'h5, 8'h10, 8'hFE);
        // hardware reset in mid-run clears what software loaded
        wr(3'h1, 8'h3C);
        rd(3'h1, 8'h3C, 8'hFF);
        i_resetn <= 1'b0;
        repeat (3) @(posedge i_clk);
        i_resetn <= 1'b1;
        @(posedge i_clk);
        rd(3'h1, 8'h00, 8'hFF);
        rd(3'h5, 8'h10, 8'hFF);
        complete_run();
    end
endmodule // tb
